//--- rtl/uflc_pkg.sv
// Constants, register map and types for the flow and loopback control block
// -----------------------------------------------------------------------
// Functional notes
// - Autoflow off: no hardware handshaking at all
// - Autoflow, RTS bit clear: honour CTS only
// - Autoflow, RTS bit set: RTS and CTS handshaking
// - Loopback holds serial transmit output high
// - Loopback ignores the external receive pin
// - Loopback feeds transmit shifter into receive shifter
// - Status bits 1, 3 and 4 raise line interrupt; bit 2 always reads zero
// - Long low receive line sets break flag
// -----------------------------------------------------------------------
package uflc_pkg;

    // -------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------
    localparam int CLK_HZ = 10_000_000;
    localparam int BAUD_RATE = 115_200;
    // Bit period rounds down; error stays under two percent at this rate
    localparam int BIT_CYCLES = CLK_HZ / BAUD_RATE;
    // Start, eight data, stop
    localparam int FRAME_BITS = 10;
    localparam int DATA_BITS = 8;

    // -------------------------------------------------------------------
    // Register offsets
    // -------------------------------------------------------------------
    localparam int ADDR_W = 6;
    localparam logic [5:0] OFS_TX_DATA = 6'h00;
    localparam logic [5:0] OFS_RX_DATA = 6'h04;
    localparam logic [5:0] OFS_MODEM_HANDSHAKE_CONTROL = 6'h10;
    localparam logic [5:0] OFS_LINE_CONDITION_STATUS = 6'h14;
    localparam logic [5:0] OFS_IRQ_STATUS = 6'h18;
    localparam logic [5:0] OFS_IRQ_MASK = 6'h1c;

    // -------------------------------------------------------------------
    // Field positions
    // -------------------------------------------------------------------
    localparam int MHC_RTS_CONTROL = 1;
    localparam int MHC_LOOPBACK = 4;
    localparam int MHC_AUTOFLOW_ENABLE = 5;
    localparam logic [31:0] MHC_WRITE_MASK = 32'h0000_0032;

    localparam int LCS_DATA_READY = 0;
    localparam int LCS_OVERRUN = 1;
    localparam int LCS_PARITY_ERR = 2;
    localparam int LCS_FRAMING_ERR = 3;
    localparam int LCS_BREAK_FLAG = 4;
    localparam int LCS_TX_HOLD_EMPTY = 5;
    localparam int LCS_TX_EMPTY = 6;

    localparam int IRQ_W = 3;
    localparam int IRQ_RX_DATA = 0;
    localparam int IRQ_LINE_ERROR = 1;
    localparam int IRQ_TX_HOLD_EMPTY = 2;

    // -------------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------------
    localparam logic [31:0] MHC_RESET = 32'h0000_0000;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

    typedef enum {
        RX_IDLE,
        RX_START,
        RX_DATA,
        RX_STOP
    } uflc_rx_state_t;

endpackage : uflc_pkg

//--- rtl/uflc_sync.sv
// Three stage input synchroniser with agreement filter
`timescale 1ns/10ps
module uflc_sync #(
    parameter logic RESET_LEVEL = 1'b1
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic async_in,
    output logic sync_out
);
    logic ff1_q;
    logic ff2_q;
    logic ff3_q;

    // Output moves only once stages two and three agree
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ff1_q <= RESET_LEVEL;
            ff2_q <= RESET_LEVEL;
            ff3_q <= RESET_LEVEL;
            sync_out <= RESET_LEVEL;
        end
        else
        begin
            ff1_q <= async_in;
            ff2_q <= ff1_q;
            ff3_q <= ff2_q;
            if (ff2_q == ff3_q)
                sync_out <= ff3_q;
        end
    end
endmodule : uflc_sync

//--- rtl/uflc_top.sv
// Serial port core with autoflow handshaking, loopback and line status
`timescale 1ns/10ps
module uflc_top #(
    parameter int BIT_CYCLES = uflc_pkg::BIT_CYCLES
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [5:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic uart_tx,
    input wire logic uart_rx,
    input wire logic cts_n,
    output logic rts_n,
    output logic irq
);
    // -------------------------------------------------------------------
    // Local constants
    // -------------------------------------------------------------------
    localparam int CHAR_CYCLES = BIT_CYCLES * uflc_pkg::FRAME_BITS;
    localparam int CW = $clog2(BIT_CYCLES + 1);
    localparam int BW = $clog2(CHAR_CYCLES + 2);
    localparam logic [CW-1:0] BIT_LAST = CW'(BIT_CYCLES - 1);
    localparam logic [CW-1:0] HALF_LAST = CW'(BIT_CYCLES / 2 - 1);
    localparam logic [BW-1:0] BREAK_COUNT = BW'(CHAR_CYCLES);
    localparam logic [2:0] DATA_LAST = 3'(uflc_pkg::DATA_BITS - 1);

    // -------------------------------------------------------------------
    // Register decode
    // -------------------------------------------------------------------
    wire wr_txd = reg_wr && (reg_addr == uflc_pkg::OFS_TX_DATA);
    wire rd_rxd = reg_rd && (reg_addr == uflc_pkg::OFS_RX_DATA);
    wire wr_mhc = reg_wr &&
        (reg_addr == uflc_pkg::OFS_MODEM_HANDSHAKE_CONTROL);
    wire rd_lcs = reg_rd &&
        (reg_addr == uflc_pkg::OFS_LINE_CONDITION_STATUS);
    wire rd_ist = reg_rd && (reg_addr == uflc_pkg::OFS_IRQ_STATUS);
    wire wr_imsk = reg_wr && (reg_addr == uflc_pkg::OFS_IRQ_MASK);

    logic [31:0] mhc_q;
    logic [2:0] imsk_q;
    logic [2:0] ist_q;
    logic [7:0] thr_q;
    logic thr_full_q;
    logic [7:0] rx_data_q;
    logic dr_q;
    logic oe_q;
    logic fe_q;
    logic bi_q;

    wire autoflow_enable = mhc_q[uflc_pkg::MHC_AUTOFLOW_ENABLE];
    wire rts_control = mhc_q[uflc_pkg::MHC_RTS_CONTROL];
    wire loopback = mhc_q[uflc_pkg::MHC_LOOPBACK];

    // Reserved positions never store, so they read back as zero
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            mhc_q <= uflc_pkg::MHC_RESET;
        else if (wr_mhc)
            mhc_q <= reg_wdata & uflc_pkg::MHC_WRITE_MASK;
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            imsk_q <= uflc_pkg::IRQ_MASK_RESET;
        else if (wr_imsk)
            imsk_q <= reg_wdata[2:0];
    end

    // -------------------------------------------------------------------
    // Pin synchronisers
    // -------------------------------------------------------------------
    logic rx_pin_s;
    logic cts_n_s;

    uflc_sync #(
        .RESET_LEVEL(1'b1)
    ) u_rx_sync (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .async_in(uart_rx),
        .sync_out(rx_pin_s)
    );

    uflc_sync #(
        .RESET_LEVEL(1'b1)
    ) u_cts_sync (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .async_in(cts_n),
        .sync_out(cts_n_s)
    );

    // -------------------------------------------------------------------
    // Flow control
    // -------------------------------------------------------------------
    // Without autoflow, CTS is not looked at and RTS stays asserted
    wire cts_flow = autoflow_enable;
    wire rts_flow = autoflow_enable && rts_control;
    wire cts_ok = !cts_flow || !cts_n_s;

    // Single character buffer, so a held character counts as full
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            rts_n <= 1'b0;
        else
            rts_n <= rts_flow && dr_q;
    end

    // -------------------------------------------------------------------
    // Transmit path
    // -------------------------------------------------------------------
    logic tx_busy;
    logic tx_line;
    // A character already shifting finishes even if CTS drops
    wire tx_start = thr_full_q && !tx_busy && cts_ok;

    uflc_tx #(
        .BIT_CYCLES(BIT_CYCLES)
    ) u_tx (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .start(tx_start),
        .data(thr_q),
        .busy(tx_busy),
        .serial(tx_line)
    );

    // A write while full overwrites the waiting character
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            thr_q <= 8'h00;
            thr_full_q <= 1'b0;
        end
        else if (wr_txd)
        begin
            thr_q <= reg_wdata[7:0];
            thr_full_q <= 1'b1;
        end
        else if (tx_start)
            thr_full_q <= 1'b0;
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            uart_tx <= 1'b1;
        else
            uart_tx <= loopback ? 1'b1 : tx_line;
    end

    // -------------------------------------------------------------------
    // Receive path
    // -------------------------------------------------------------------
    // Loopback skips the pin synchroniser: same clock, no crossing
    wire rx_in = loopback ? tx_line : rx_pin_s;

    uflc_pkg::uflc_rx_state_t rx_state_q;
    uflc_pkg::uflc_rx_state_t rx_state_d;
    logic [CW-1:0] rx_cnt_q;
    logic [CW-1:0] rx_cnt_d;
    logic [2:0] rx_bit_q;
    logic [2:0] rx_bit_d;
    logic [7:0] rx_shift_q;
    logic [7:0] rx_shift_d;
    logic rx_done;
    logic rx_frame_err;

    wire bit_end = (rx_cnt_q == BIT_LAST);
    wire half_end = (rx_cnt_q == HALF_LAST);
    wire [CW-1:0] cnt_inc = rx_cnt_q + CW'(1);

    always_comb
    begin
        rx_state_d = rx_state_q;
        rx_cnt_d = cnt_inc;
        rx_bit_d = rx_bit_q;
        rx_shift_d = rx_shift_q;
        rx_done = 1'b0;
        rx_frame_err = 1'b0;
        case (rx_state_q)
            uflc_pkg::RX_IDLE:
            begin
                rx_cnt_d = '0;
                if (!rx_in)
                    rx_state_d = uflc_pkg::RX_START;
            end
            uflc_pkg::RX_START:
            begin
                if (half_end)
                begin
                    rx_cnt_d = '0;
                    rx_bit_d = 3'h0;
                    rx_state_d = rx_in ? uflc_pkg::RX_IDLE :
                        uflc_pkg::RX_DATA;
                end
            end
            uflc_pkg::RX_DATA:
            begin
                if (bit_end)
                begin
                    rx_cnt_d = '0;
                    rx_shift_d = {rx_in, rx_shift_q[7:1]};
                    rx_bit_d = rx_bit_q + 3'h1;
                    if (rx_bit_q == DATA_LAST)
                        rx_state_d = uflc_pkg::RX_STOP;
                end
            end
            uflc_pkg::RX_STOP:
            begin
                if (bit_end)
                begin
                    rx_cnt_d = '0;
                    rx_done = 1'b1;
                    rx_frame_err = !rx_in;
                    rx_state_d = uflc_pkg::RX_IDLE;
                end
            end
            default:
            begin
                rx_cnt_d = '0;
                rx_state_d = uflc_pkg::RX_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_state_q <= uflc_pkg::RX_IDLE;
            rx_cnt_q <= '0;
            rx_bit_q <= 3'h0;
            rx_shift_q <= 8'h00;
        end
        else
        begin
            rx_state_q <= rx_state_d;
            rx_cnt_q <= rx_cnt_d;
            rx_bit_q <= rx_bit_d;
            rx_shift_q <= rx_shift_d;
        end
    end

    // Low time counter saturates one past the character time
    logic [BW-1:0] low_cnt_q;
    wire break_hit = !rx_in && (low_cnt_q == BREAK_COUNT);

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            low_cnt_q <= '0;
        else if (rx_in)
            low_cnt_q <= '0;
        else if (low_cnt_q <= BREAK_COUNT)
            low_cnt_q <= low_cnt_q + BW'(1);
    end

    // -------------------------------------------------------------------
    // Line condition status
    // -------------------------------------------------------------------
    wire set_oe = rx_done && dr_q && !rd_rxd;
    wire line_event = set_oe || rx_frame_err || break_hit;

    // Sets win over the clearing read in the same cycle
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_data_q <= 8'h00;
            dr_q <= 1'b0;
            oe_q <= 1'b0;
            fe_q <= 1'b0;
            bi_q <= 1'b0;
        end
        else
        begin
            if (rx_done)
                rx_data_q <= rx_shift_q;
            dr_q <= rx_done || (dr_q && !rd_rxd);
            oe_q <= set_oe || (oe_q && !rd_lcs);
            fe_q <= rx_frame_err || (fe_q && !rd_lcs);
            bi_q <= break_hit || (bi_q && !rd_lcs);
        end
    end

    // Status is read only; a write to its offset is simply dropped
    wire [31:0] lcs_value = {25'h0,
        !thr_full_q && !tx_busy,
        !thr_full_q,
        bi_q,
        fe_q,
        1'b0,
        oe_q,
        dr_q};

    // -------------------------------------------------------------------
    // Interrupts
    // -------------------------------------------------------------------
    logic [2:0] ist_set;
    always_comb
    begin
        ist_set = 3'h0;
        ist_set[uflc_pkg::IRQ_RX_DATA] = rx_done;
        ist_set[uflc_pkg::IRQ_LINE_ERROR] = line_event;
        ist_set[uflc_pkg::IRQ_TX_HOLD_EMPTY] = tx_start;
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            ist_q <= 3'h0;
        else
            ist_q <= ist_set | (ist_q & {3{!rd_ist}});
    end

    // Mask bit one acts as the line error interrupt enable
    assign irq = |(ist_q & imsk_q);

    // -------------------------------------------------------------------
    // Read data
    // -------------------------------------------------------------------
    logic [31:0] rd_value;
    always_comb
    begin
        case (reg_addr)
            uflc_pkg::OFS_RX_DATA:
                rd_value = {24'h0, rx_data_q};
            uflc_pkg::OFS_MODEM_HANDSHAKE_CONTROL:
                rd_value = mhc_q;
            uflc_pkg::OFS_LINE_CONDITION_STATUS:
                rd_value = lcs_value;
            uflc_pkg::OFS_IRQ_STATUS:
                rd_value = {29'h0, ist_q};
            uflc_pkg::OFS_IRQ_MASK:
                rd_value = {29'h0, imsk_q};
            default:
                rd_value = 32'h0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            reg_rdata <= 32'h0;
        else
            reg_rdata <= reg_rd ? rd_value : 32'h0;
    end
endmodule : uflc_top

//--- rtl/uflc_tx.sv
// Transmit shifter: one 8N1 character per start pulse
`timescale 1ns/10ps
module uflc_tx #(
    parameter int BIT_CYCLES = uflc_pkg::BIT_CYCLES
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic start,
    input wire logic [7:0] data,
    output logic busy,
    output logic serial
);
    localparam int CW = $clog2(BIT_CYCLES + 1);
    localparam logic [CW-1:0] BIT_LAST = CW'(BIT_CYCLES - 1);
    localparam logic [3:0] LAST_BIT = 4'(uflc_pkg::FRAME_BITS - 1);

    logic [9:0] frame_q;
    logic [CW-1:0] cnt_q;
    logic [3:0] bit_q;
    wire bit_end = busy && (cnt_q == BIT_LAST);
    wire frame_end = bit_end && (bit_q == LAST_BIT);

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            busy <= 1'b0;
            frame_q <= 10'h3ff;
            cnt_q <= '0;
            bit_q <= 4'h0;
        end
        else if (start && !busy)
        begin
            busy <= 1'b1;
            frame_q <= {1'b1, data, 1'b0};
            cnt_q <= '0;
            bit_q <= 4'h0;
        end
        else if (frame_end)
        begin
            busy <= 1'b0;
            frame_q <= 10'h3ff;
        end
        else if (bit_end)
        begin
            cnt_q <= '0;
            bit_q <= bit_q + 4'h1;
            frame_q <= {1'b1, frame_q[9:1]};
        end
        else if (busy)
            cnt_q <= cnt_q + CW'(1);
    end

    assign serial = frame_q[0];
endmodule : uflc_tx

//--- verification/uart_flow_loopback_control_tb.sv
// Self-checking bench for the flow and loopback control block
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    err_total++; \
    $display("MISMATCH %0t got %0h exp %0h", $time, (g), (e)); end end
module uart_flow_loopback_control_tb;
    // -------------------------------------------------------------
    // Harness
    // -------------------------------------------------------------
    localparam int BIT = 8;
    localparam logic [5:0] A_TX = 6'h00;
    localparam logic [5:0] A_RX = 6'h04;
    localparam logic [5:0] A_MHC = 6'h10;
    localparam logic [5:0] A_LCS = 6'h14;
    localparam logic [5:0] A_IST = 6'h18;
    localparam logic [5:0] A_MSK = 6'h1c;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [5:0] reg_addr = 6'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic uart_tx;
    logic uart_rx;
    logic cts_n;
    logic rts_n;
    logic irq;
    int err_total = 0;
    int samples_checked = 0;
    logic [31:0] rv;
    logic [31:0] rb;
    logic [7:0] b;
    logic [7:0] c;
    always #50 sys_clk = ~sys_clk;
    uflc_top #(.BIT_CYCLES(BIT)) i_dut (
        .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .uart_tx(uart_tx), .uart_rx(uart_rx),
        .cts_n(cts_n), .rts_n(rts_n), .irq(irq)
    );
    uflc_remote #(.BIT_CYCLES(BIT)) i_rem (
        .sys_clk(sys_clk), .uart_tx(uart_tx), .uart_rx(uart_rx),
        .cts_n(cts_n)
    );
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [5:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cyc
    task automatic wrap_up;
        $display("Comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up
    // Bounded wait for the remote end to collect one character
    task automatic wait_got(input logic [7:0] e);
        logic [7:0] g;
        int n;
        n = 0;
        while (i_rem.got_q.size() == 0 && n < 300)
        begin
            cyc(1);
            n++;
        end
        if (i_rem.got_q.size() == 0)
        begin
            err_total++;
            $display("MISMATCH %0t no character at remote end", $time);
            wrap_up();
        end
        g = i_rem.got_q.pop_front();
        `CHK(g, e)
    endtask : wait_got
    initial
    begin
        rv = $urandom(32'hf949039b);
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        // Status register is only ever read
        rd(A_MHC, rv);
        `CHK(rv, 32'h0)
        rd(A_LCS, rv);
        `CHK(rv, 32'h60)
        `CHK({uart_tx, rts_n, irq}, 3'b100)
        repeat (4)
        begin
            rv = $urandom();
            wr(A_MHC, rv);
            rd(A_MHC, rb);
            `CHK(rb, rv & 32'h0000_0032)
        end
        rd(6'h3c, rv);
        `CHK(rv, 32'h0)
        wr(A_MHC, 32'h0);
        wr(A_MSK, 32'h7);
        i_rem.pins(1'b1, 1'b1);
        b = $urandom();
        wr(A_TX, {24'h0, b});
        wait_got(b);
        c = $urandom();
        i_rem.send(c);
        cyc(8);
        `CHK(irq, 1'b1)
        rd(A_IST, rv);
        `CHK(rv[2:0], 3'h5)
        rd(A_RX, rv);
        `CHK(rv[7:0], c)
        `CHK(irq, 1'b0)
        wr(A_MHC, 32'h10);
        i_rem.pins(1'b0, 1'b1);
        b = $urandom();
        wr(A_TX, {24'h0, b});
        cyc(110);
        `CHK(i_rem.got_q.size(), 0)
        rd(A_LCS, rv);
        `CHK(rv[6:0], 7'h61)
        rd(A_RX, rv);
        `CHK(rv[7:0], b)
        i_rem.pins(1'b1, 1'b1);
        wr(A_MHC, 32'h20);
        rd(A_IST, rv);
        b = $urandom();
        wr(A_TX, {24'h0, b});
        cyc(90);
        `CHK(i_rem.got_q.size(), 0)
        c = $urandom();
        i_rem.send(c);
        cyc(8);
        `CHK(rts_n, 1'b0)
        i_rem.pins(1'b1, 1'b0);
        wait_got(b);
        rd(A_RX, rv);
        `CHK(rv[7:0], c)
        wr(A_MHC, 32'h22);
        c = $urandom();
        i_rem.send(c);
        cyc(8);
        `CHK(rts_n, 1'b1)
        rd(A_RX, rv);
        `CHK(rv[7:0], c)
        cyc(2);
        `CHK(rts_n, 1'b0)
        wr(A_MHC, 32'h0);
        rd(A_IST, rv);
        wr(A_MSK, 32'h0);
        i_rem.pins(1'b0, 1'b0);
        cyc(100);
        i_rem.pins(1'b1, 1'b0);
        cyc(8);
        `CHK(irq, 1'b0)
        wr(A_MSK, 32'h2);
        cyc(0);
        `CHK(irq, 1'b1)
        rd(A_LCS, rv);
        `CHK(rv[4:1], 4'b1100)
        rd(A_LCS, rv);
        `CHK(rv[4:1], 4'b0000)
        rd(A_IST, rv);
        `CHK(rv[1], 1'b1)
        `CHK(irq, 1'b0)
        rd(A_RX, rv);
        `CHK(rv[7:0], 8'h00)
        wrap_up();
    end
endmodule : uart_flow_loopback_control_tb
bind uflc_top uflc_monitor #(.BIT_CYCLES(BIT_CYCLES)) i_mon (
    .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .uart_tx(uart_tx), .uart_rx(uart_rx),
    .cts_n(cts_n), .rts_n(rts_n), .irq(irq)
);

//--- verification/uflc_monitor.sv
// Port checker for the flow and loopback control block
`timescale 1ns/10ps
module uflc_monitor #(
    parameter int BIT_CYCLES = 8
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [5:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic uart_tx,
    input wire logic uart_rx,
    input wire logic cts_n,
    input wire logic rts_n,
    input wire logic irq
);
    // -------------------------------------------------------------
    // Shadow state
    // -------------------------------------------------------------
    localparam int QMAX = BIT_CYCLES * 10;
    logic [31:0] mhc_q;
    logic [2:0] mask_q;
    int quiet_q;
    int cts_q;
    wire on_mhc = reg_addr == 6'h10;
    wire rd_mhc = reg_rd && on_mhc;
    wire rd_lcs = reg_rd && reg_addr == 6'h14;
    wire tx_wr = reg_wr && reg_addr == 6'h00;
    wire lb = mhc_q[4];
    wire af = mhc_q[5];
    wire af_cts = af && !mhc_q[1];
    // Idle only counts outside loopback, where the shifter runs unseen
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mhc_q <= 32'h0;
            mask_q <= 3'h0;
            quiet_q <= 0;
            cts_q <= 0;
        end
        else
        begin
            if (reg_wr && on_mhc)
                mhc_q <= reg_wdata & 32'h0000_0032;
            if (reg_wr && reg_addr == 6'h1c)
                mask_q <= reg_wdata[2:0];
            quiet_q <= (uart_tx && !lb) ? quiet_q + (quiet_q < QMAX) : 0;
            cts_q <= cts_n ? cts_q + (cts_q < 15) : 0;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    a_loop_tx_high: assert property (lb && $past(lb) |-> uart_tx)
        else $error("Serial output low in loopback");
    a_rts_off_low: assert property (!af && !$past(af) |-> !rts_n)
        else $error("Request line moved without autoflow");
    a_cts_only_rts:
        assert property (af_cts && $past(af_cts) |-> !rts_n)
        else $error("Request line moved in clear-only mode");
    a_cts_hold_tx:
        assert property (af && !lb && cts_q >= 6 && quiet_q >= QMAX
            |-> uart_tx)
        else $error("Character started while clear to send is off");
    // Output is registered, so the low start bit is first seen on the
    // third sampling edge after the write
    a_tx_start_two:
        assert property (tx_wr && !lb && !af && quiet_q >= QMAX
            |-> ##1 uart_tx [*2] ##1 !uart_tx)
        else $error("Start bit not two cycles after write");
    a_mhc_readback:
        assert property ($past(rd_mhc) |-> reg_rdata == $past(mhc_q))
        else $error("Control register read wrong");
    a_lcs_zero_bits:
        assert property ($past(rd_lcs) |-> reg_rdata[31:7] == 25'h0
            && !reg_rdata[2])
        else $error("Line status unused bits set");
    a_irq_masked: assert property (mask_q == 3'h0 |-> !irq)
        else $error("Interrupt with all sources masked");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("Read data outside its cycle");
    c_loopback: cover property (lb && $past(rd_lcs));
    c_cts_hold: cover property (af && cts_q >= 6 && quiet_q >= QMAX);
    c_irq: cover property (irq && mask_q == 3'h2);
endmodule : uflc_monitor

//--- verification/uflc_remote.sv
// Remote serial port model: 8N1 sender, receiver and clear-to-send
`timescale 1ns/10ps
module uflc_remote #(
    parameter int BIT_CYCLES = 8
) (
    input wire logic sys_clk,
    input wire logic uart_tx,
    output logic uart_rx,
    output logic cts_n
);
    logic [7:0] got_q[$];
    logic [7:0] sh;
    logic [9:0] frm;
    initial
    begin
        uart_rx = 1'b1;
        cts_n = 1'b0;
    end
    task automatic pins(input logic rx, input logic cts);
        @(posedge sys_clk);
        uart_rx <= rx;
        cts_n <= cts;
    endtask : pins
    // Line rests high after the stop bit, as a real idle line does
    task automatic send(input logic [7:0] d);
        frm = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            @(posedge sys_clk);
            uart_rx <= frm[i];
            repeat (BIT_CYCLES - 1) @(posedge sys_clk);
        end
    endtask : send
    always
    begin
        @(negedge uart_tx);
        repeat (BIT_CYCLES / 2) @(posedge sys_clk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT_CYCLES) @(posedge sys_clk);
            sh[i] = uart_tx;
        end
        repeat (BIT_CYCLES) @(posedge sys_clk);
        if (uart_tx)
            got_q.push_back(sh);
    end
endmodule : uflc_remote
